// [src/ebc_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Post-self-refresh precharge adds 1..11 states
// - Compare flag writes only clear it
// - Refresh counter 8-bit, R/W, clocked
// - Match sets flag, clears counter
// - Match with refresh enabled starts refresh
// - Match, refresh off, enable set: interrupt
// - Counter resets zero, kept in standby
// - Period resets all ones, kept standby
// - Eight 2-Mbyte areas in 16 Mbyte
// - Normal mode controls 64 Kbyte area0
// - Width bit 0=16, 1=8; bus mode
// - State bit 0=2-state, no waits
// - 3-state area inserts 0..7 waits
// - Read strobe negated early or end
// - Extension states assert select and address strobe, not RD/WR
// - Reset: basic interface, 3-state access
// - Interface type set by area 2 field only
// - DRAM areas use selects as row strobes
// - SDRAM: selects carry RAS/CAS/WE/clock
// - Accessed area select driven low
// - RAM enable puts RAM in area7
// - Select pins output only when enabled
// - Clock select halts or divides clock
// - Interrupt enable forced zero when refreshing
module ebc_top
    import ebc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hw_standby,
    input  wire logic        advanced_mode,
    input  wire logic        rom_enabled,
    input  wire logic        mode_8bit,
    input  wire logic        selfref_exit,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire ebc_req_t    mreq,
    output logic             mdone,
    output logic             internal_ram_hit,
    output ebc_pins_t        pins,
    output logic             refresh_start,
    output logic             compare_irq,
    output logic             bus_8bit_mode,
    output logic             early_rd_half
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]  area_width_control_q;
    logic [7:0]  area_state_control_q;
    logic [23:0] wait_control_q;
    logic [7:0]  read_strobe_timing_control_q;
    logic [15:0] select_extension_control_q;
    logic [15:0] iftype_q;
    logic [15:0] dram_access_control_q;
    logic        compare_match_flag_q;
    logic        compare_irq_enable_q;
    logic [2:0]  refresh_clk_sel_q;
    logic        refresh_enable_q;
    logic [7:0]  refresh_timer_count_q;
    logic [7:0]  refresh_period_compare_q;
    logic        onchip_ram_enable_q;
    logic [7:0]  sel_dir_q;
    logic [7:0]  sel_func_q;
    logic [11:0] prescale_q;

    logic        wr_en;
    logic        rd_en;
    logic        tick;
    logic        match;
    logic        sdram_mode;
    logic        dram_mode;

    assign wr_en = psel && penable && pwrite && ce;
    assign rd_en = psel && !penable && !pwrite && ce;
    assign match = (refresh_timer_count_q == refresh_period_compare_q);
    assign sdram_mode = (iftype_q[5:4] == IF_ALT2);
    assign dram_mode  = (iftype_q[5:4] == IF_ALT1);

    // ************************************************************
    // APB slave, zero wait states
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            if (paddr == OFS_WIDTH) begin
                prdata <= {24'h000000, area_width_control_q};
            end else if (paddr == OFS_STATE) begin
                prdata <= {24'h000000, area_state_control_q};
            end else if (paddr == OFS_WAIT) begin
                prdata <= {8'h00, wait_control_q};
            end else if (paddr == OFS_RDSTB) begin
                prdata <= {24'h000000, read_strobe_timing_control_q};
            end else if (paddr == OFS_CSEXT) begin
                prdata <= {16'h0000, select_extension_control_q};
            end else if (paddr == OFS_IFTYPE) begin
                prdata <= {16'h0000, iftype_q};
            end else if (paddr == OFS_DRAM) begin
                prdata <= {16'h0000, dram_access_control_q};
            end else if (paddr == OFS_REFCTL) begin
                prdata <= {16'h0000, compare_match_flag_q, compare_irq_enable_q, 2'b00,
                           1'b0, refresh_clk_sel_q, refresh_enable_q, 7'h00};
            end else if (paddr == OFS_COUNT) begin
                prdata <= {24'h000000, refresh_timer_count_q};
            end else if (paddr == OFS_PERIOD) begin
                prdata <= {24'h000000, refresh_period_compare_q};
            end else if (paddr == OFS_SYS) begin
                prdata <= {31'h00000000, onchip_ram_enable_q};
            end else if (paddr == OFS_PINCTL) begin
                prdata <= {16'h0000, sel_func_q, sel_dir_q};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // Bus specification registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            area_width_control_q <= {8{mode_8bit}};
            area_state_control_q <= RST_STATE;
            wait_control_q       <= RST_WAIT;
            read_strobe_timing_control_q <= RST_ZERO8;
            select_extension_control_q   <= 16'h0000;
            iftype_q             <= 16'h0000;
            dram_access_control_q <= 16'h0000;
            onchip_ram_enable_q  <= 1'b1;
            sel_dir_q            <= {7'h00, !rom_enabled};
            sel_func_q           <= {7'h00, !rom_enabled};
        end else if (wr_en) begin
            if (paddr == OFS_WIDTH) begin
                area_width_control_q <= pwdata[7:0];
            end else if (paddr == OFS_STATE) begin
                area_state_control_q <= pwdata[7:0];
            end else if (paddr == OFS_WAIT) begin
                wait_control_q <= pwdata[23:0];
            end else if (paddr == OFS_RDSTB) begin
                read_strobe_timing_control_q <= pwdata[7:0];
            end else if (paddr == OFS_CSEXT) begin
                select_extension_control_q <= pwdata[15:0];
            end else if (paddr == OFS_IFTYPE) begin
                // Areas 0,1,6 one alternative; bit 15 flags continuous DRAM
                iftype_q <= {pwdata[15:14], 1'b0, pwdata[12], pwdata[11:4],
                             1'b0, pwdata[2], 1'b0, pwdata[0]};
            end else if (paddr == OFS_DRAM) begin
                dram_access_control_q <= pwdata[15:0];
            end else if (paddr == OFS_SYS) begin
                onchip_ram_enable_q <= pwdata[0];
            end else if (paddr == OFS_PINCTL) begin
                sel_dir_q  <= pwdata[7:0];
                sel_func_q <= pwdata[15:8];
            end
        end
    end

    // ************************************************************
    // Refresh timer
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            refresh_clk_sel_q    <= 3'b000;
            refresh_enable_q     <= 1'b0;
            compare_irq_enable_q <= 1'b0;
        end else if (wr_en && paddr == OFS_REFCTL) begin
            refresh_clk_sel_q <= pwdata[REF_CKS_LSB +: 3];
            refresh_enable_q  <= pwdata[REF_EN_BIT];
            compare_irq_enable_q <= pwdata[REF_COMPARE_IRQ_ENABLE_BIT] && !pwdata[REF_EN_BIT];
        end else if (ce && refresh_enable_q) begin
            compare_irq_enable_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            prescale_q <= 12'h000;
        end else if (ce) begin
            prescale_q <= prescale_q + 12'h001;
        end
    end

    // Divider taps: 2, 8, 32 ... 4096
    always_comb begin
        case (refresh_clk_sel_q)
            3'b001:  tick = prescale_q[0:0] == 1'b1;
            3'b010:  tick = prescale_q[2:0] == 3'h7;
            3'b011:  tick = prescale_q[4:0] == 5'h1F;
            3'b100:  tick = prescale_q[6:0] == 7'h7F;
            3'b101:  tick = prescale_q[8:0] == 9'h1FF;
            3'b110:  tick = prescale_q[10:0] == 11'h7FF;
            3'b111:  tick = prescale_q[11:0] == 12'hFFF;
            default: tick = 1'b0;
        endcase
    end

    // Software standby needs no branch: state simply holds
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            refresh_timer_count_q <= RST_COUNT;
        end else if (ce) begin
            if (match) begin
                refresh_timer_count_q <= RST_COUNT;
            end else if (wr_en && paddr == OFS_COUNT) begin
                refresh_timer_count_q <= pwdata[7:0];
            end else if (tick) begin
                refresh_timer_count_q <= refresh_timer_count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            refresh_period_compare_q <= RST_PERIOD;
        end else if (wr_en && paddr == OFS_PERIOD) begin
            refresh_period_compare_q <= pwdata[7:0];
        end
    end

    // Set beats clear so no match is lost
    always_ff @(posedge clk) begin
        if (!rstn || hw_standby) begin
            compare_match_flag_q <= 1'b0;
        end else if (ce) begin
            if (match) begin
                compare_match_flag_q <= 1'b1;
            end else if (refresh_start && refresh_enable_q) begin
                compare_match_flag_q <= 1'b0;
            end else if (wr_en && paddr == OFS_REFCTL && !pwdata[REF_CMF_BIT]
                         && !refresh_enable_q) begin
                compare_match_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            refresh_start <= 1'b0;
            compare_irq   <= 1'b0;
            bus_8bit_mode <= 1'b0;
        end else if (ce) begin
            refresh_start <= match && refresh_enable_q;
            compare_irq   <= (compare_match_flag_q || match) && !refresh_enable_q
                             && compare_irq_enable_q;
            bus_8bit_mode <= &area_width_control_q;
        end
    end

    // ************************************************************
    // External bus cycle sequencer
    // ************************************************************
    ebc_state_t  state_q;
    logic [2:0]  area_q;
    logic [2:0]  cnt_q;
    logic        wr_q;
    logic [2:0]  area_d;
    logic        ext_hit;
    logic        three_state;
    logic [2:0]  waits;
    logic [3:0]  pre_len;
    logic [3:0]  pre_cnt_q;

    always_comb begin
        area_d  = mreq.addr[AREA_SHIFT +: 3];
        ext_hit = 1'b1;
        if (!advanced_mode) begin
            area_d  = 3'd0;
            ext_hit = (mreq.addr & ~NORMAL_MASK) == 24'h000000;
        end
        if (area_d == 3'd7 && onchip_ram_enable_q) begin
            ext_hit = 1'b0;
        end
    end

    assign three_state = area_state_control_q[area_q];
    assign waits       = three_state ? wait_control_q[area_q*3 +: 3] : 3'd0;
    assign pre_len = {2'b00, dram_access_control_q[DRAM_TPC_LSB +: 2]}
                     + {1'b0, dram_access_control_q[DRAM_SPC_LSB +: 3]};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q          <= ST_IDLE;
            area_q           <= 3'd0;
            cnt_q            <= 3'd0;
            pre_cnt_q        <= 4'd0;
            wr_q             <= 1'b0;
            mdone            <= 1'b0;
            internal_ram_hit <= 1'b0;
        end else if (ce) begin
            mdone            <= 1'b0;
            internal_ram_hit <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Skip the done cycle: the master still holds req then
                    if (selfref_exit) begin
                        pre_cnt_q <= pre_len;
                        state_q   <= ST_PRE;
                    end else if (mreq.req && !mdone && !ext_hit) begin
                        internal_ram_hit <= 1'b1;
                        mdone            <= 1'b1;
                    end else if (mreq.req && !mdone) begin
                        area_q  <= area_d;
                        wr_q    <= mreq.wr;
                        state_q <= select_extension_control_q[8 + area_d] ? ST_HEAD : ST_T1;
                    end
                end
                ST_HEAD: state_q <= ST_T1;
                ST_T1:   state_q <= ST_T2;
                ST_T2: begin
                    cnt_q <= waits;
                    if (!three_state) begin
                        state_q <= select_extension_control_q[area_q] ? ST_TAIL : ST_IDLE;
                        mdone   <= !select_extension_control_q[area_q];
                    end else begin
                        state_q <= (waits != 3'd0) ? ST_WAIT : ST_T3;
                    end
                end
                ST_WAIT: begin
                    cnt_q <= cnt_q - 3'd1;
                    if (cnt_q == 3'd1) begin
                        state_q <= ST_T3;
                    end
                end
                ST_T3: begin
                    state_q <= select_extension_control_q[area_q] ? ST_TAIL : ST_IDLE;
                    mdone   <= !select_extension_control_q[area_q];
                end
                ST_TAIL: begin
                    state_q <= ST_IDLE;
                    mdone   <= 1'b1;
                end
                ST_PRE: begin
                    pre_cnt_q <= pre_cnt_q - 4'd1;
                    if (pre_cnt_q == 4'd0) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Pin drive, registered
    // ************************************************************
    logic active;
    logic strobe;
    logic last_strobe;

    assign active = (state_q != ST_IDLE) && (state_q != ST_PRE);
    assign strobe = (state_q == ST_T2) || (state_q == ST_WAIT) || (state_q == ST_T3);
    assign last_strobe = three_state ? (state_q == ST_T3) : (state_q == ST_T2);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pins.as_n     <= 1'b1;
            pins.rd_n     <= 1'b1;
            pins.hwr_n    <= 1'b1;
            pins.lwr_n    <= 1'b1;
            pins.oe_n     <= 1'b1;
            pins.sel_oe_n <= 8'hFF;
            early_rd_half <= 1'b0;
        end else if (ce) begin
            pins.as_n     <= !active;
            pins.rd_n     <= !(strobe && !wr_q);
            pins.hwr_n    <= !(strobe && wr_q);
            pins.lwr_n    <= !(strobe && wr_q && !area_width_control_q[area_q]);
            pins.oe_n     <= sdram_mode ? 1'b0 : !(strobe && !wr_q);
            pins.sel_oe_n <= ~(sel_dir_q & sel_func_q);
            // Half-state negation needs the fast clock edge outside
            early_rd_half <= last_strobe && !wr_q
                             && read_strobe_timing_control_q[area_q];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sel
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    pins.sel_n[gi] <= 1'b1;
                end else if (ce) begin
                    if (sdram_mode && gi >= 2 && gi <= 5) begin
                        // RAS/CAS/WE idle high, memory clock toggles
                        pins.sel_n[gi] <= (gi == 5) ? prescale_q[0] : 1'b1;
                    end else if (dram_mode && gi >= 2 && gi <= 5 && iftype_q[15]) begin
                        // Continuous space: row strobe on area 2 only
                        pins.sel_n[gi] <= !(gi == 2 && active && area_q >= 3'd2
                                            && area_q <= 3'd5);
                    end else begin
                        pins.sel_n[gi] <= !(active && area_q == gi);
                    end
                end
            end
        end
    endgenerate

endmodule

// [pkg/ebc_pkg.sv]
package ebc_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_WIDTH     = 8'h00;
    localparam logic [7:0] OFS_STATE     = 8'h04;
    localparam logic [7:0] OFS_WAIT      = 8'h08;
    localparam logic [7:0] OFS_RDSTB     = 8'h0C;
    localparam logic [7:0] OFS_CSEXT     = 8'h10;
    localparam logic [7:0] OFS_IFTYPE    = 8'h14;
    localparam logic [7:0] OFS_DRAM      = 8'h18;
    localparam logic [7:0] OFS_REFCTL    = 8'h1C;
    localparam logic [7:0] OFS_COUNT     = 8'h20;
    localparam logic [7:0] OFS_PERIOD    = 8'h24;
    localparam logic [7:0] OFS_SYS       = 8'h28;
    localparam logic [7:0] OFS_PINCTL    = 8'h2C;

    // ************************************************************
    // Field positions in the refresh control and DRAM access control registers
    // ************************************************************
    localparam int REF_CMF_BIT   = 15;
    localparam int REF_COMPARE_IRQ_ENABLE_BIT  = 14;
    localparam int REF_CKS_LSB   = 8;
    localparam int REF_EN_BIT    = 7;
    localparam int DRAM_TPC_LSB  = 12;
    localparam int DRAM_SPC_LSB  = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_COUNT  = 8'h00;
    localparam logic [7:0]  RST_PERIOD = 8'hFF;
    localparam logic [7:0]  RST_STATE  = 8'hFF;
    localparam logic [23:0] RST_WAIT   = 24'hFFFFFF;
    localparam logic [7:0]  RST_ZERO8  = 8'h00;

    // ************************************************************
    // Area decode
    // ************************************************************
    localparam int AREA_SHIFT = 21;
    localparam logic [23:0] NORMAL_MASK = 24'h00FFFF;

    typedef enum logic [1:0] {
        IF_BASIC = 2'b00,
        IF_ALT1  = 2'b01,
        IF_ALT2  = 2'b10
    } ebc_iftype_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HEAD  = 3'b001,
        ST_T1    = 3'b010,
        ST_T2    = 3'b011,
        ST_WAIT  = 3'b100,
        ST_T3    = 3'b101,
        ST_TAIL  = 3'b110,
        ST_PRE   = 3'b111
    } ebc_state_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic        word;
        logic [23:0] addr;
    } ebc_req_t;

    typedef struct packed {
        logic       as_n;
        logic       rd_n;
        logic       hwr_n;
        logic       lwr_n;
        logic [7:0] sel_n;
        logic [7:0] sel_oe_n;
        logic       oe_n;
    } ebc_pins_t;

endpackage

// [tb/ebc_props.sv]
`timescale 1ns/1ps
// ************************************************************
// Port checker
// ************************************************************
module ebc_props
    import ebc_pkg::*;
(
    input wire logic      clk,
    input wire logic      rstn,
    input wire logic      ce,
    input wire logic      psel,
    input wire logic      penable,
    input wire logic      pready,
    input wire logic      pslverr,
    input wire ebc_req_t  mreq,
    input wire logic      mdone,
    input wire logic      internal_ram_hit,
    input wire ebc_pins_t pins,
    input wire logic      refresh_start,
    input wire logic      compare_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_ONE_SEL: assert property ($onehot0(~pins.sel_n))
        else $error("more than one select low");
    AST_RAM_NOSEL: assert property (internal_ram_hit |-> &pins.sel_n)
        else $error("select low on internal ram hit");
    AST_STB_IN_SEL: assert property (&pins.sel_n |->
        pins.rd_n && pins.hwr_n && pins.lwr_n)
        else $error("strobe outside select");
    AST_DONE_REQ: assert property (mdone |-> mreq.req)
        else $error("done without request");
    AST_REF_IRQ: assert property (refresh_start |-> !compare_irq)
        else $error("irq with refresh on");
    AST_REF_PULSE: assert property (refresh_start |=> !refresh_start)
        else $error("refresh start too long");
    AST_APB_READY: assert property (psel && !penable && ce ##1 ce |->
        pready && !pslverr)
        else $error("no ready in access");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    COV_DONE: cover property (mdone);
    COV_REF: cover property (refresh_start);
    COV_IRQ: cover property ($rose(compare_irq));
endmodule

// [tb/ebc_mem_model.sv]
`timescale 1ns/1ps
// ************************************************************
// Passive external device: logs select area and length
// ************************************************************
module ebc_mem_model
    import ebc_pkg::*;
(
    input wire logic      clk,
    input wire ebc_pins_t pins,
    output logic [2:0]    area,
    output int            len
);
    int cnt = 0;
    initial len = 0;
    always @(posedge clk) begin
        if (pins.sel_n != 8'hFF) begin
            cnt++;
            for (int i = 0; i < 8; i++) if (!pins.sel_n[i]) area <= i[2:0];
        end else if (cnt != 0) begin
            len <= cnt;
            cnt = 0;
        end
    end
endmodule

// [tb/ebc_tb_top.sv]
`timescale 1ns/1ps
// ************************************************************
// Bench
// ************************************************************
module ebc_tb_top;
    import ebc_pkg::*;
    logic        clk = 0, rstn = 0, hw_standby = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, mdone, internal_ram_hit, refresh_start, compare_irq;
    logic        bus_8bit_mode, early_rd_half, selfref_exit = 0;
    ebc_req_t    mreq = '0;
    ebc_pins_t   pins;
    logic [2:0]  area;
    int          len, miscompares = 0, check_count = 0, cyc = 0, seed = 48635;
    int          st, w, h, t, i, tp, x, erh = 0, nrd = 0;
    always #2.5 clk = ~clk;
    ebc_top i_ebc_top(.clk, .rstn, .ce(1'b1), .hw_standby, .advanced_mode(1'b1),
        .rom_enabled(1'b0), .mode_8bit(1'b0), .selfref_exit, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mreq, .mdone,
        .internal_ram_hit, .pins, .refresh_start, .compare_irq, .bus_8bit_mode,
        .early_rd_half);
    ebc_mem_model i_ebc_mem_model(.clk, .pins, .area, .len);
    task summarize;
        if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    always @(posedge clk) if (early_rd_half === 1'b1) erh++;
    // Hang guard: whole run is a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rd(OFS_COUNT, 32'h00);
        rd(OFS_PERIOD, 32'hFF);
        rd(OFS_STATE, 32'hFF);
        chk({24'h0, pins.sel_oe_n}, 32'hFE);
        apb(1, OFS_PERIOD, 32'h5A);
        hw_standby <= 1;
        @(posedge clk);
        hw_standby <= 0;
        @(posedge clk);
        rd(OFS_PERIOD, 32'hFF);
        apb(1, OFS_WIDTH, 32'hFF);
        repeat (2) @(posedge clk);
        chk(bus_8bit_mode, 1);
        apb(1, OFS_WIDTH, 32'h7F);
        apb(1, OFS_PINCTL, 32'hFFFF);
        apb(1, OFS_SYS, 32'h0);
        chk(bus_8bit_mode, 0);
        chk({24'h0, pins.sel_oe_n}, 32'h00);
        apb(1, OFS_RDSTB, 32'hFF);
        for (int a = 0; a < 8; a++) begin
            st = $random(seed) & 1; w = $random(seed) & 7;
            h = $random(seed) & 1; t = $random(seed) & 1;
            apb(1, OFS_STATE, st << a);
            apb(1, OFS_WAIT, w << (3 * a));
            apb(1, OFS_CSEXT, (h << (8 + a)) | (t << a));
            mreq <= {1'b1, st[0], 1'b0, a[2:0], 21'h000100};
            for (i = 0; i < 100 && mdone !== 1'b1; i++) @(posedge clk);
            mreq.req <= 1'b0;
            repeat (4) @(posedge clk);
            chk(area, a);
            chk(len, (st ? 3 + w : 2) + h + t);
            nrd += (st == 0);
        end
        chk(erh, nrd);
        apb(1, OFS_SYS, 32'h1);
        mreq <= {1'b1, 1'b0, 1'b0, 24'hE00100};
        for (i = 0; i < 100 && mdone !== 1'b1; i++) @(posedge clk);
        mreq.req <= 1'b0;
        chk({internal_ram_hit, mdone}, 3);
        tp = $random(seed) & 3; x = $random(seed) & 7;
        apb(1, OFS_DRAM, (tp << 12) | x);
        selfref_exit <= 1; mreq <= {1'b1, 1'b0, 1'b0, 24'h000100};
        @(posedge clk);
        selfref_exit <= 0;
        for (i = 0; i < 100 && mdone !== 1'b1; i++) @(posedge clk);
        mreq.req <= 1'b0;
        chk(i, 5 + tp + x);
        apb(1, OFS_PERIOD, 32'h4 + ($random(seed) & 3));
        apb(1, OFS_REFCTL, 32'h4100);
        for (i = 0; i < 500 && compare_irq !== 1'b1; i++) @(posedge clk);
        chk(compare_irq, 1);
        apb(1, OFS_REFCTL, 32'hC000);
        rd(OFS_REFCTL, 32'hC000);
        apb(1, OFS_COUNT, 32'h3);
        repeat (10) @(posedge clk);
        rd(OFS_COUNT, 32'h3);
        apb(1, OFS_REFCTL, 32'h4000);
        rd(OFS_REFCTL, 32'h4000);
        chk(compare_irq, 0);
        apb(1, OFS_REFCTL, 32'hC180);
        for (i = 0; i < 500 && refresh_start !== 1'b1; i++) @(posedge clk);
        chk(refresh_start, 1);
        apb(0, OFS_REFCTL, 32'h0);
        chk({r[14], compare_irq}, 0);
        rd(8'h3C, 32'h0);
        summarize();
    end
endmodule
bind ebc_top ebc_props i_ebc_props(.clk, .rstn, .ce, .psel, .penable, .pready, .pslverr,
    .mreq, .mdone, .internal_ram_hit, .pins, .refresh_start, .compare_irq);
